// File: rtl/agc_control.sv
`timescale 1ns/1ps
module agc_control
    import agc_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic serial_clk,
    input wire logic serial_cs_n,
    input wire logic serial_din,
    output logic serial_dout,
    input wire logic overload_warning,
    input wire logic adc_reset_event,
    input wire logic iq_valid,
    input wire logic [15:0] i_sample,
    input wire logic [15:0] q_sample,
    input wire logic out_sample_strobe,
    output logic [7:0] vga_dac_code,
    output logic atten_enable,
    output logic vga_standby,
    output logic agc_active,
    output logic [7:0] ssi_overload_count,
    output logic [7:0] ssi_reset_count,
    output logic [7:0] ssi_gain,
    output logic ssi_status_valid
);

    ////////////////////////////////////////////////////////////////////////////////
    // Register port.

    logic [6:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata;
    logic reg_wr;

    serial_reg_port u_port (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .serial_clk(serial_clk),
        .serial_cs_n(serial_cs_n),
        .serial_din(serial_din),
        .serial_dout(serial_dout),
        .reg_addr(reg_addr),
        .reg_wdata(reg_wdata),
        .reg_wr(reg_wr),
        .reg_rd(),
        .reg_rdata(reg_rdata)
    );

    logic [7:0] standby_ff, nxt_standby, high_ff, nxt_high, rates_ff, nxt_rates;
    logic [7:0] weight_ref_ff, nxt_weight_ref, cfg_ff, nxt_cfg;
    logic [15:0] word_ff, nxt_word;
    logic [14:0] gain_ff, nxt_gain;
    logic active_ff;

    // The high byte is only staged; the word takes effect on the low byte write,
    // which is why the high byte has to go first.
    always_comb
    begin
        nxt_standby = standby_ff;
        nxt_high = high_ff;
        nxt_word = word_ff;
        nxt_rates = rates_ff;
        nxt_weight_ref = weight_ref_ff;
        nxt_cfg = cfg_ff;
        if (reg_wr)
        begin
            if (reg_addr == ADDR_STANDBY)
            begin
                nxt_standby = reg_wdata;
            end
            else if (reg_addr == ADDR_GAIN_HIGH)
            begin
                nxt_high = reg_wdata;
            end
            else if (reg_addr == ADDR_GAIN_LOW)
            begin
                nxt_word = {high_ff, reg_wdata};
            end
            else if (reg_addr == ADDR_RATES)
            begin
                nxt_rates = reg_wdata;
            end
            else if (reg_addr == ADDR_WEIGHT_REF)
            begin
                nxt_weight_ref = reg_wdata;
            end
            else if (reg_addr == ADDR_SERIAL_CFG)
            begin
                nxt_cfg = reg_wdata;
            end
        end
    end

    // Reads of the gain bytes show the live gain, so software can watch the loop.
    always_comb
    begin
        if (reg_addr == ADDR_STANDBY)
        begin
            reg_rdata = standby_ff;
        end
        else if (reg_addr == ADDR_GAIN_HIGH)
        begin
            reg_rdata = {word_ff[ATTEN_BIT], gain_ff[14:8]};
        end
        else if (reg_addr == ADDR_GAIN_LOW)
        begin
            reg_rdata = gain_ff[7:0];
        end
        else if (reg_addr == ADDR_RATES)
        begin
            reg_rdata = rates_ff;
        end
        else if (reg_addr == ADDR_WEIGHT_REF)
        begin
            reg_rdata = weight_ref_ff;
        end
        else if (reg_addr == ADDR_SERIAL_CFG)
        begin
            reg_rdata = cfg_ff;
        end
        else
        begin
            reg_rdata = 8'h00;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            standby_ff <= STANDBY_RST;
            high_ff <= GAIN_HIGH_RST;
            word_ff <= {GAIN_HIGH_RST, GAIN_LOW_RST};
            rates_ff <= RATES_RST;
            weight_ref_ff <= WEIGHT_REF_RST;
            cfg_ff <= SERIAL_CFG_RST;
            active_ff <= 1'b0;
        end
        else
        begin
            standby_ff <= nxt_standby;
            high_ff <= nxt_high;
            word_ff <= nxt_word;
            rates_ff <= nxt_rates;
            weight_ref_ff <= nxt_weight_ref;
            cfg_ff <= nxt_cfg;
            active_ff <= (nxt_weight_ref[REF_LSB +: 3] != 3'h0);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Loop.

    logic [2:0] ref_code;
    logic [3:0] attack_code, decay_code, weight_code;
    logic auto_mode;

    assign ref_code = weight_ref_ff[REF_LSB +: 3];
    assign attack_code = rates_ff[ATTACK_LSB +: 4];
    assign decay_code = rates_ff[DECAY_LSB +: 4];
    assign weight_code = weight_ref_ff[WEIGHT_LSB +: 4];
    assign auto_mode = (ref_code != 3'h0);

    // Scale an error by 2^(eff/2 - LOOP_SHIFT_BASE); an odd code adds a half step to approximate root two.
    function automatic logic [17:0] scale_err(input logic [17:0] mag, input int eff);
        int sh;
        logic [17:0] base;
        sh = LOOP_SHIFT_BASE - (eff >>> 1);
        base = mag >> sh;
        if (eff[0])
        begin
            scale_err = base + (base >> 1);
        end
        else
        begin
            scale_err = base;
        end
    endfunction

    logic ovl_s1_ff, ovl_s2_ff, ovl_s3_ff;
    logic [4:0] div_ff, nxt_div;
    logic [16:0] est_ff, nxt_est;
    logic rst_pend_ff, nxt_rst_pend;
    logic [7:0] ovl_cnt_ff, nxt_ovl_cnt, rcnt_ff, nxt_rcnt;
    logic [7:0] ssi_ovl_ff, nxt_ssi_ovl, ssi_rst_ff, nxt_ssi_rst, ssi_gain_ff, nxt_ssi_gain;
    logic ssi_valid_ff, nxt_ssi_valid, standby_control_out_ff;
    logic tick, ovl_rise;
    logic [15:0] abs_i, abs_q, ovl_step;
    logic [17:0] err, step;
    logic [18:0] sum;

    // The comparator output is analog-side and asynchronous.
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ovl_s1_ff <= 1'b0;
            ovl_s2_ff <= 1'b0;
            ovl_s3_ff <= 1'b0;
        end
        else
        begin
            ovl_s1_ff <= overload_warning;
            ovl_s2_ff <= ovl_s1_ff;
            ovl_s3_ff <= ovl_s2_ff;
        end
    end

    assign tick = (div_ff == UPDATE_DIV_LAST);
    assign ovl_rise = ovl_s2_ff & ~ovl_s3_ff;
    assign abs_i = i_sample[15] ? 16'(-i_sample) : i_sample;
    assign abs_q = q_sample[15] ? 16'(-q_sample) : q_sample;
    assign ovl_step = OVL_STEP_MAX >> (4'(CODE_MAX) - weight_code);
    assign err = {1'b0, ref_of(ref_code)} - {1'b0, est_ff};

    always_comb
    begin
        nxt_div = tick ? 5'h00 : div_ff + 5'h01;
        nxt_est = iq_valid ? 17'(abs_i + abs_q + 17'h00000) : est_ff;
        nxt_rst_pend = rst_pend_ff;
        nxt_gain = gain_ff;
        step = 18'h00000;
        sum = {4'h0, gain_ff};
        if (tick)
        begin
            if (!auto_mode)
            begin
                nxt_gain = word_ff[14:0];
            end
            else if (ovl_s2_ff || rst_pend_ff)
            begin
                // Overload and converter reset override the digital estimate.
                sum = {4'h0, gain_ff} - {3'h0, ovl_step};
                nxt_rst_pend = 1'b0;
            end
            else if (err[17])
            begin
                step = scale_err(18'(-err), int'(attack_code));
                sum = {4'h0, gain_ff} - {1'b0, step};
            end
            else
            begin
                step = scale_err(err, int'(attack_code) - int'(decay_code));
                sum = {4'h0, gain_ff} + {1'b0, step};
            end
            if (auto_mode)
            begin
                if (sum[18])
                begin
                    nxt_gain = GAIN_MIN;
                end
                else if (sum[17:0] > {3'h0, GAIN_MAX})
                begin
                    nxt_gain = GAIN_MAX;
                end
                else
                begin
                    nxt_gain = sum[14:0];
                end
            end
        end
        // A reset event in the consuming cycle stays pending for the next update.
        if (adc_reset_event)
        begin
            nxt_rst_pend = 1'b1;
        end
    end

    // Counters close each output sample; an event on the closing cycle opens the next count.
    always_comb
    begin
        nxt_ovl_cnt = ovl_cnt_ff;
        nxt_rcnt = rcnt_ff;
        nxt_ssi_ovl = ssi_ovl_ff;
        nxt_ssi_rst = ssi_rst_ff;
        nxt_ssi_gain = ssi_gain_ff;
        nxt_ssi_valid = 1'b0;
        if (out_sample_strobe)
        begin
            nxt_ovl_cnt = {7'h00, ovl_rise};
            nxt_rcnt = {7'h00, adc_reset_event};
            if (cfg_ff[CFG_STATUS_BIT])
            begin
                nxt_ssi_ovl = ovl_cnt_ff;
                nxt_ssi_rst = rcnt_ff;
                nxt_ssi_gain = gain_ff[14:7];
                nxt_ssi_valid = 1'b1;
            end
        end
        else
        begin
            if (ovl_rise && ovl_cnt_ff != COUNT_MAX)
            begin
                nxt_ovl_cnt = ovl_cnt_ff + 8'h01;
            end
            if (adc_reset_event && rcnt_ff != COUNT_MAX)
            begin
                nxt_rcnt = rcnt_ff + 8'h01;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            div_ff <= 5'h00;
            est_ff <= 17'h00000;
            rst_pend_ff <= 1'b0;
            gain_ff <= {GAIN_HIGH_RST[6:0], GAIN_LOW_RST};
            ovl_cnt_ff <= 8'h00;
            rcnt_ff <= 8'h00;
            ssi_ovl_ff <= 8'h00;
            ssi_rst_ff <= 8'h00;
            ssi_gain_ff <= 8'h00;
            ssi_valid_ff <= 1'b0;
            standby_control_out_ff <= 1'b0;
        end
        else
        begin
            div_ff <= nxt_div;
            est_ff <= nxt_est;
            rst_pend_ff <= nxt_rst_pend;
            gain_ff <= nxt_gain;
            ovl_cnt_ff <= nxt_ovl_cnt;
            rcnt_ff <= nxt_rcnt;
            ssi_ovl_ff <= nxt_ssi_ovl;
            ssi_rst_ff <= nxt_ssi_rst;
            ssi_gain_ff <= nxt_ssi_gain;
            ssi_valid_ff <= nxt_ssi_valid;
            standby_control_out_ff <= standby_ff[STANDBY_CONTROL_VGA_BIT];
        end
    end

    assign vga_dac_code = gain_ff[14:7];
    assign atten_enable = word_ff[ATTEN_BIT];
    assign vga_standby = standby_control_out_ff;
    assign agc_active = active_ff;
    assign ssi_overload_count = ssi_ovl_ff;
    assign ssi_reset_count = ssi_rst_ff;
    assign ssi_gain = ssi_gain_ff;
    assign ssi_status_valid = ssi_valid_ff;

endmodule

// File: shared/agc_pkg.sv
package agc_pkg;

    // Register indices on the serial port.
    localparam logic [6:0] ADDR_STANDBY = 7'h00;
    localparam logic [6:0] ADDR_GAIN_HIGH = 7'h03;
    localparam logic [6:0] ADDR_GAIN_LOW = 7'h04;
    localparam logic [6:0] ADDR_RATES = 7'h05;
    localparam logic [6:0] ADDR_WEIGHT_REF = 7'h06;
    localparam logic [6:0] ADDR_SERIAL_CFG = 7'h07;

    // Field positions.
    localparam int STANDBY_CONTROL_VGA_BIT = 0;
    localparam int ATTACK_LSB = 4;
    localparam int DECAY_LSB = 0;
    localparam int WEIGHT_LSB = 4;
    localparam int REF_LSB = 0;
    localparam int CFG_STATUS_BIT = 0;
    localparam int ATTEN_BIT = 15;

    // Reset values.
    localparam logic [7:0] STANDBY_RST = 8'h00;
    localparam logic [7:0] GAIN_HIGH_RST = 8'h3f;
    localparam logic [7:0] GAIN_LOW_RST = 8'hff;
    localparam logic [7:0] RATES_RST = 8'h00;
    localparam logic [7:0] WEIGHT_REF_RST = 8'h00;
    localparam logic [7:0] SERIAL_CFG_RST = 8'h00;

    // Serial frame: read flag, 7-bit address, 8-bit data, most significant bit first.
    localparam logic [4:0] HEADER_LAST = 5'h07;
    localparam logic [4:0] FRAME_LAST = 5'h0f;
    localparam logic [4:0] FRAME_BITS = 5'h10;

    // Loop timing: one update per twenty converter clocks.
    localparam logic [4:0] UPDATE_DIV_LAST = 5'h13;

    // Loop arithmetic.
    localparam logic [14:0] GAIN_MAX = 15'h7fff;
    localparam logic [14:0] GAIN_MIN = 15'h0000;
    localparam logic [15:0] OVL_STEP_MAX = 16'h1eb8;
    localparam int CODE_MAX = 15;
    localparam int LOOP_SHIFT_BASE = 12;
    localparam logic [7:0] COUNT_MAX = 8'hff;

    // Estimate scale: |I|+|Q| at the clip level.
    localparam logic [16:0] REF_3DB = 17'h0b53c;
    localparam logic [16:0] REF_6DB = 17'h08050;
    localparam logic [16:0] REF_9DB = 17'h05ad4;
    localparam logic [16:0] REF_12DB = 17'h0404e;
    localparam logic [16:0] REF_15DB = 17'h02d85;

    function automatic logic [16:0] ref_of(input logic [2:0] code);
        case (code)
            3'h1: ref_of = REF_3DB;
            3'h2: ref_of = REF_6DB;
            3'h3: ref_of = REF_9DB;
            3'h4: ref_of = REF_12DB;
            default: ref_of = REF_15DB;
        endcase
    endfunction

endpackage

// File: rtl/serial_reg_port.sv
`timescale 1ns/1ps
module serial_reg_port
    import agc_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic serial_clk,
    input wire logic serial_cs_n,
    input wire logic serial_din,
    output logic serial_dout,
    output logic [6:0] reg_addr,
    output logic [7:0] reg_wdata,
    output logic reg_wr,
    output logic reg_rd,
    input wire logic [7:0] reg_rdata
);

    logic cs_s1_ff, cs_s2_ff, clk_s1_ff, clk_s2_ff, clk_s3_ff, din_s1_ff, din_s2_ff;
    logic [15:0] shift_ff, nxt_shift;
    logic [4:0] cnt_ff, nxt_cnt;
    logic [6:0] addr_ff, nxt_addr;
    logic [7:0] wdata_ff, nxt_wdata, out_ff, nxt_out;
    logic read_ff, nxt_read, wr_ff, nxt_wr, rd_ff, nxt_rd, dout_ff, nxt_dout;
    logic rise, fall;

    // Pins are asynchronous to ref_clk; edges are taken from the second and third stages.
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cs_s1_ff <= 1'b1;
            cs_s2_ff <= 1'b1;
            clk_s1_ff <= 1'b0;
            clk_s2_ff <= 1'b0;
            clk_s3_ff <= 1'b0;
            din_s1_ff <= 1'b0;
            din_s2_ff <= 1'b0;
        end
        else
        begin
            cs_s1_ff <= serial_cs_n;
            cs_s2_ff <= cs_s1_ff;
            clk_s1_ff <= serial_clk;
            clk_s2_ff <= clk_s1_ff;
            clk_s3_ff <= clk_s2_ff;
            din_s1_ff <= serial_din;
            din_s2_ff <= din_s1_ff;
        end
    end

    assign rise = clk_s2_ff & ~clk_s3_ff;
    assign fall = ~clk_s2_ff & clk_s3_ff;

    always_comb
    begin
        nxt_shift = shift_ff;
        nxt_cnt = cnt_ff;
        nxt_addr = addr_ff;
        nxt_wdata = wdata_ff;
        nxt_read = read_ff;
        nxt_wr = 1'b0;
        nxt_rd = 1'b0;
        nxt_out = out_ff;
        nxt_dout = dout_ff;
        if (cs_s2_ff)
        begin
            nxt_cnt = 5'h00;
            nxt_read = 1'b0;
        end
        else
        begin
            if (rise && cnt_ff != FRAME_BITS)
            begin
                nxt_shift = {shift_ff[14:0], din_s2_ff};
                nxt_cnt = cnt_ff + 5'h01;
                if (cnt_ff == HEADER_LAST)
                begin
                    nxt_addr = nxt_shift[6:0];
                    nxt_read = nxt_shift[7];
                    nxt_rd = nxt_shift[7];
                end
                if (cnt_ff == FRAME_LAST && !read_ff)
                begin
                    nxt_wdata = nxt_shift[7:0];
                    nxt_wr = 1'b1;
                end
            end
            // The read answer is captured the cycle after the address settles.
            if (rd_ff)
            begin
                nxt_out = reg_rdata;
            end
            else if (fall && read_ff && cnt_ff > HEADER_LAST && cnt_ff != FRAME_BITS)
            begin
                nxt_dout = out_ff[7];
                nxt_out = {out_ff[6:0], 1'b0};
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            shift_ff <= 16'h0000;
            cnt_ff <= 5'h00;
            addr_ff <= 7'h00;
            wdata_ff <= 8'h00;
            read_ff <= 1'b0;
            wr_ff <= 1'b0;
            rd_ff <= 1'b0;
            out_ff <= 8'h00;
            dout_ff <= 1'b0;
        end
        else
        begin
            shift_ff <= nxt_shift;
            cnt_ff <= nxt_cnt;
            addr_ff <= nxt_addr;
            wdata_ff <= nxt_wdata;
            read_ff <= nxt_read;
            wr_ff <= nxt_wr;
            rd_ff <= nxt_rd;
            out_ff <= nxt_out;
            dout_ff <= nxt_dout;
        end
    end

    assign serial_dout = dout_ff;
    assign reg_addr = addr_ff;
    assign reg_wdata = wdata_ff;
    assign reg_wr = wr_ff;
    assign reg_rd = rd_ff;

endmodule

// File: dv/agc_control_asserts.sv
`timescale 1ns/1ps
module agc_control_asserts
    import agc_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic overload_warning,
    input wire logic adc_reset_event,
    input wire logic out_sample_strobe,
    input wire logic [7:0] vga_dac_code,
    input wire logic atten_enable,
    input wire logic vga_standby,
    input wire logic agc_active,
    input wire logic [7:0] ssi_overload_count,
    input wire logic [7:0] ssi_reset_count,
    input wire logic [7:0] ssi_gain,
    input wire logic ssi_status_valid
);
////////////////////////////////////////
    logic [7:0] prev_code_ff;
    logic [9:0] gap_ff;
    logic [9:0] nxt_gap;
    logic [4:0] run_ff;
    logic [4:0] nxt_run;
    logic [7:0] rev_ff;
    logic [7:0] nxt_rev;
    logic [7:0] cap_ff;
    logic [7:0] nxt_cap;

    // Cycles since the gain code moved, cycles in automatic mode, resets in this period.
    always_comb
    begin
        nxt_gap = (gap_ff == 10'h3ff) ? gap_ff : gap_ff + 10'h001;
        if (vga_dac_code != prev_code_ff)
            nxt_gap = 10'h000;
        nxt_run = (run_ff == 5'h1f) ? run_ff : run_ff + 5'h01;
        if (!agc_active)
            nxt_run = 5'h00;
        nxt_rev = (adc_reset_event && rev_ff != COUNT_MAX) ? rev_ff + 8'h01 : rev_ff;
        nxt_cap = cap_ff;
        if (out_sample_strobe)
        begin
            nxt_rev = {7'h00, adc_reset_event};
            nxt_cap = rev_ff;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            prev_code_ff <= 8'h7f;
            gap_ff <= 10'h3ff;
            run_ff <= 5'h00;
            rev_ff <= 8'h00;
            cap_ff <= 8'h00;
        end
        else
        begin
            prev_code_ff <= vga_dac_code;
            gap_ff <= nxt_gap;
            run_ff <= nxt_run;
            rev_ff <= nxt_rev;
            cap_ff <= nxt_cap;
        end
    end
////////////////////////////////////////
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_n);

    sequence s_ovl_held;
        (overload_warning && agc_active)[*6];
    endsequence

    sequence s_status_pulse;
        out_sample_strobe ##1 (ssi_status_valid && !out_sample_strobe);
    endsequence

    AST_RESET_VALUE: assert property ($rose(rst_n) |-> vga_dac_code == 8'h7f
        && !atten_enable && !vga_standby && !ssi_status_valid)
        else $error("Outputs left reset values at release.");
    AST_TICK_GRID: assert property (vga_dac_code != prev_code_ff |->
        gap_ff == 10'h3ff || gap_ff % 10'h014 == 10'h013)
        else $error("Gain code moved off the update grid.");
    AST_STATUS_CAUSE: assert property (ssi_status_valid |-> $past(out_sample_strobe))
        else $error("Status valid without a strobe.");
    AST_STATUS_ONE_CYCLE: assert property (s_status_pulse |=> !ssi_status_valid)
        else $error("Status valid held too long.");
    AST_FIELDS_HOLD: assert property ($changed({ssi_overload_count, ssi_reset_count,
        ssi_gain}) |-> ssi_status_valid)
        else $error("Status fields moved without valid.");
    AST_RESET_COUNT: assert property (ssi_status_valid |-> ssi_reset_count == cap_ff)
        else $error("Reset count wrong.");
    AST_OVL_DOWN: assert property (s_ovl_held |-> vga_dac_code <= $past(vga_dac_code))
        else $error("Gain rose during overload.");
    AST_NO_WRAP: assert property (vga_dac_code != prev_code_ff && run_ff == 5'h1f |->
        8'(vga_dac_code - prev_code_ff + 8'h3e) <= 8'h7c)
        else $error("Gain code jumped as if wrapped.");
endmodule

bind agc_control agc_control_asserts u_asserts (.*);

// File: dv/serial_host.sv
`timescale 1ns/1ps
module serial_host
    import agc_pkg::*;
(
    input wire logic ref_clk,
    output logic serial_clk,
    output logic serial_cs_n,
    output logic serial_din,
    input wire logic serial_dout
);
    // Six cycles a phase gives margin over the minimum the pin synchronisers need.
    localparam int HALF = 6;
    int now_cyc = 0;
    int last_gain = -1000;

    initial
    begin
        serial_clk = 1'b0;
        serial_cs_n = 1'b1;
        serial_din = 1'b1;
    end

    always @(posedge ref_clk)
        now_cyc <= now_cyc + 1;

    task automatic xfer(input logic rd, input logic [6:0] addr, input logic [7:0] wdata,
        output logic [7:0] rdata);
        logic [15:0] frame;
        frame = {rd, addr, wdata};
        rdata = 8'h00;
        @(posedge ref_clk);
        serial_cs_n <= 1'b0;
        for (int i = 15; i >= 0; i--)
        begin
            @(posedge ref_clk);
            serial_clk <= 1'b0;
            serial_din <= frame[i];
            repeat (HALF) @(posedge ref_clk);
            if (i < 8)
                rdata[i] = serial_dout;
            serial_clk <= 1'b1;
            repeat (HALF) @(posedge ref_clk);
        end
        // Once released, the line shows the inverse of its last bit, never a held value.
        serial_clk <= 1'b0;
        serial_din <= ~frame[0];
        serial_cs_n <= 1'b1;
        repeat (4) @(posedge ref_clk);
    endtask

    task automatic write_gain(input logic [15:0] word);
        logic [7:0] unused;
        while (now_cyc - last_gain < 100)
            @(posedge ref_clk);
        xfer(1'b0, ADDR_GAIN_HIGH, word[15:8], unused);
        xfer(1'b0, ADDR_GAIN_LOW, word[7:0], unused);
        last_gain = now_cyc;
    endtask

    task automatic toggle_standby;
        logic [7:0] unused;
        xfer(1'b0, ADDR_STANDBY, 8'h00, unused);
        xfer(1'b0, ADDR_STANDBY, 8'h01, unused);
    endtask
endmodule

// File: dv/vga_agc_control_loop_bench.sv
`timescale 1ns/1ps
module vga_agc_control_loop_bench
    import agc_pkg::*;
();
    logic ref_clk;
    logic rst_n;
    logic serial_clk;
    logic serial_cs_n;
    logic serial_din;
    logic serial_dout;
    logic overload_warning;
    logic adc_reset_event;
    logic iq_valid;
    logic out_sample_strobe;
    logic [15:0] i_sample;
    logic [15:0] q_sample;
    logic [7:0] vga_dac_code;
    logic atten_enable;
    logic vga_standby;
    logic agc_active;
    logic [7:0] ssi_overload_count;
    logic [7:0] ssi_reset_count;
    logic [7:0] ssi_gain;
    logic ssi_status_valid;
    int err_total = 0;
    int samples_checked = 0;
    int seed = 32'h457b;
    int nr;
    int no;
    int wts [3] = '{15, 14, 12};
    logic [7:0] start;
    logic [15:0] word;
    logic [16:0] refs [1:5] = '{REF_3DB, REF_6DB, REF_9DB, REF_12DB, REF_15DB};

    agc_control DUT (.*);
    serial_host host (.*);

    initial
    begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end
////////////////////////////////////////
    task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
        samples_checked++;
        if (got !== exp)
        begin
            err_total++;
            $display("ERROR at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic complete_run;
        $display("Mismatches %0d, checks %0d", err_total, samples_checked);
        if (err_total == 0 && samples_checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        logic [7:0] unused;
        host.xfer(1'b0, a, d, unused);
    endtask

    task automatic rd_chk(input logic [6:0] a, input logic [7:0] exp);
        logic [7:0] got;
        host.xfer(1'b1, a, 8'h00, got);
        check(got, exp, "register read");
    endtask

    // Drives a constant estimate; I and Q split it, Q always negative and I negative only when neg is set.
    task automatic feed(input logic [16:0] est, input logic neg, input int cycles);
        logic [15:0] a;
        logic [15:0] b;
        a = est[16:1];
        b = 16'(est - {1'b0, a});
        for (int k = 0; k < cycles; k++)
        begin
            @(posedge ref_clk);
            iq_valid <= (k % 4 == 0);
            i_sample <= neg ? -a : a;
            q_sample <= -b;
        end
        @(posedge ref_clk);
        iq_valid <= 1'b0;
    endtask

    task automatic strobe;
        @(posedge ref_clk);
        out_sample_strobe <= 1'b1;
        @(posedge ref_clk);
        out_sample_strobe <= 1'b0;
        @(posedge ref_clk);
    endtask

    function automatic logic [7:0] ovl_exp(input int w);
        logic [15:0] g;
        g = 16'h4000 - (OVL_STEP_MAX >> (15 - w));
        return g[14:7];
    endfunction
////////////////////////////////////////
    initial
    begin
        repeat (60000) @(posedge ref_clk);
        err_total++;
        $display("ERROR at %0t: watchdog expired", $time);
        complete_run();
    end

    initial
    begin
        rst_n = 1'b0;
        overload_warning = 1'b0;
        adc_reset_event = 1'b0;
        iq_valid = 1'b0;
        out_sample_strobe = 1'b0;
        i_sample = 16'h0000;
        q_sample = 16'h0000;
        repeat (12) @(posedge ref_clk);
        rst_n <= 1'b1;
        @(posedge ref_clk);
        check(vga_dac_code, 8'h7f, "reset code");
        check({5'h00, atten_enable, vga_standby, agc_active}, 8'h00, "reset flags");
        repeat (40) @(posedge ref_clk);
        rd_chk(ADDR_GAIN_HIGH, GAIN_HIGH_RST);
        rd_chk(ADDR_GAIN_LOW, GAIN_LOW_RST);
        rd_chk(7'h10, 8'h00);
        for (int k = 0; k < 3; k++)
        begin
            word = (k == 0) ? 16'h8000 : 16'($random(seed));
            host.write_gain(word);
            repeat (25) @(posedge ref_clk);
            check(vga_dac_code, word[14:7], "manual code");
            check(8'(atten_enable), 8'(word[15]), "attenuator");
        end
        wr(ADDR_STANDBY, 8'h01);
        check(8'(vga_standby), 8'h01, "standby on");
        host.toggle_standby();
        check(8'(vga_standby), 8'h01, "standby kept");
        wr(ADDR_STANDBY, 8'h00);
        check(8'(vga_standby), 8'h00, "standby off");
        wr(ADDR_SERIAL_CFG, 8'h01);
        strobe();
        nr = ($random(seed) & 3) + 1;
        no = ($random(seed) & 3) + 1;
        repeat (2 * nr) @(posedge ref_clk) adc_reset_event <= ~adc_reset_event;
        for (int k = 0; k < 2 * no; k++)
            repeat (4) @(posedge ref_clk) overload_warning <= (k % 2 == 0);
        repeat (4) @(posedge ref_clk);
        strobe();
        check(8'(ssi_status_valid), 8'h01, "status valid");
        check(ssi_reset_count, 8'(nr), "reset count");
        check(ssi_overload_count, 8'(no), "overload count");
        check(ssi_gain, word[14:7], "status gain");
        @(posedge ref_clk);
        check(8'(ssi_status_valid), 8'h00, "valid one cycle");
        wr(ADDR_SERIAL_CFG, 8'h00);
        strobe();
        check({ssi_status_valid, ssi_reset_count[6:0]}, 8'(nr), "status disabled");
        for (int c = 0; c < 8; c++)
        begin
            wr(ADDR_WEIGHT_REF, 8'(c));
            check(8'(agc_active), 8'(c != 0), "auto enable");
        end
        wr(ADDR_WEIGHT_REF, 8'h00);
        wr(ADDR_RATES, 8'hf2);
        host.write_gain(16'h4000);
        for (int c = 1; c < 6; c++)
        begin
            wr(ADDR_WEIGHT_REF, 8'(c));
            feed(refs[c] + 17'h00800, 1'b1, 40);
            start = vga_dac_code;
            feed(refs[c] + 17'h00800, 1'b1, 200);
            check(8'(vga_dac_code < start), 8'h01, "gain falls");
            start = vga_dac_code;
            feed(refs[c] - 17'h00800, $random(seed) & 1, 200);
            check(8'(vga_dac_code > start), 8'h01, "gain rises");
        end
        for (int k = 0; k < 3; k++)
        begin
            wr(ADDR_WEIGHT_REF, 8'h00);
            host.write_gain(16'h4000);
            repeat (40) @(posedge ref_clk);
            check(vga_dac_code, 8'h80, "manual restore");
            overload_warning <= 1'b1;
            wr(ADDR_WEIGHT_REF, {4'(wts[k]), 4'h1});
            for (int n = 0; n < 300 && vga_dac_code === 8'h80; n++)
                @(posedge ref_clk);
            check(vga_dac_code, ovl_exp(wts[k]), "overload step");
            repeat (400) @(posedge ref_clk);
            check(vga_dac_code, 8'h00, "gain floor");
            overload_warning <= 1'b0;
        end
        complete_run();
    end
endmodule
